/* include/mse_defines.svh */
`ifndef MSE_DEFINES_SVH
`define MSE_DEFINES_SVH
// Register byte offsets
`define MSE_OFF_CTRL 12'h000
`define MSE_OFF_STAT 12'h004
`define MSE_OFF_INFO 12'h008
`define MSE_OFF_IDX 12'h00C
`define MSE_OFF_DIV 12'h010
`define MSE_OFF_RING 12'h014
// Control fields
`define MSE_CTRL_STEP 0
// Status fields
`define MSE_STAT_IDLE 0
`define MSE_STAT_DETECT 1
`define MSE_STAT_LISTEN 2
`define MSE_STAT_BUSY 3
`define MSE_STAT_PENDING 4
// Info fields
`define MSE_INFO_ERR 31
`define MSE_INFO_ERR_OVF 30
`define MSE_INFO_COR 29
`define MSE_INFO_COR_OVF 28
// Ring include field
`define MSE_RING_PCIE 0
// Reset values and counts
`define MSE_DIV_RESET 16'h00FF
`define MSE_DIV_W 16
`define MSE_IRQ_SOURCE_BIT 20
// AXI responses
`define MSE_RESP_OKAY 2'h0
`define MSE_RESP_SLVERR 2'h2
`endif

/* include/mse_pkg.sv */
package mse_pkg;
  typedef enum logic [1:0]
  {
    MSE_IDLE = 2'h0,
    MSE_LISTEN = 2'h1,
    MSE_DETECT = 2'h3
  } mse_state_e;

  typedef struct packed
  {
    logic err;
    logic err_ovf;
    logic cor;
    logic cor_ovf;
    logic [27:0] addr;
  } mse_ind_s;

  typedef struct packed
  {
    logic ue;
    logic ce;
    logic addr_ok;
    logic [27:0] addr;
  } mse_event_s;
endpackage

/* design/mse_monitor.sv */
// Operation
// - Three states; reset enters idle
// - Idle: memories store, nothing reported
// - Listen: indication sets pending flag, interrupt
// - Detect presents info and memory index
// - Status shows idle, detect, listen flags
// - Step bit stays set until state reached
// - Busy flag high while transitioning
// - First step clears memories, goes to listen
// - PCIe memories included only when enabled
// - One indication per memory; cleared when read
// - Indication holds four flags and address
// - Uncorrectable with address sets error flag
// - Uncorrectable without address sets error overflow
// - Correctable with address sets correctable flag
// - Correctable without address sets correctable overflow
// - Uncorrectable information outranks correctable
// - Address recorded only while listening
// - Device reset keeps memory contents
// - Interrupt occupies source bit twenty
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mse_defines.svh"
module mse_monitor #(
  parameter int NUM_MEM = 8,
  parameter int PCIE_MEM = 7,
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory upset events, one per memory
  input wire mse_pkg::mse_event_s [NUM_MEM-1:0] mem_event,
  // PCIe enable and ring control
  input wire logic pcie_enabled,
  // Monitor outputs
  output logic integrity_interrupt,
  output logic [NUM_MEM-1:0] mem_detect_clear
);

  initial
  begin
    if (NUM_MEM < 1 || NUM_MEM > 256 || PCIE_MEM >= NUM_MEM || ADDR_W < 5)
      $error("mse_monitor: bad parameters");
  end

  localparam int IW = (NUM_MEM > 1) ? $clog2(NUM_MEM) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  mse_pkg::mse_state_e state_reg;
  logic step_request_reg;
  logic started_reg;
  logic busy_reg;
  logic pending_reg;
  logic [`MSE_DIV_W-1:0] div_reg;
  logic [`MSE_DIV_W-1:0] tick_cnt_reg;
  logic pcie_mac_ring_include_reg;
  mse_pkg::mse_ind_s upset_info_reg;
  logic [IW-1:0] upset_memory_index_reg;
  logic [IW-1:0] scan_reg;
  mse_pkg::mse_ind_s store_reg [NUM_MEM];
  logic [NUM_MEM-1:0] stored_reg;
  logic [NUM_MEM-1:0] clear_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic rd_fire;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_reg <= 1'b0;
    end
  end

  logic wr_known;
  always_comb
  begin
    unique case (awaddr_reg[ADDR_W-1:0])
      ADDR_W'(`MSE_OFF_CTRL), ADDR_W'(`MSE_OFF_STAT), ADDR_W'(`MSE_OFF_INFO),
      ADDR_W'(`MSE_OFF_IDX), ADDR_W'(`MSE_OFF_DIV), ADDR_W'(`MSE_OFF_RING): wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSE_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  logic wr_ctrl;
  logic wr_div;
  logic wr_ring;
  assign wr_ctrl = wr_fire && wstrb_reg[0] && awaddr_reg == ADDR_W'(`MSE_OFF_CTRL);
  assign wr_div = wr_fire && awaddr_reg == ADDR_W'(`MSE_OFF_DIV);
  assign wr_ring = wr_fire && wstrb_reg[0] && awaddr_reg == ADDR_W'(`MSE_OFF_RING);

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [31:0] rd_word;
  logic rd_known;
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(`MSE_OFF_CTRL): rd_word[`MSE_CTRL_STEP] = step_request_reg;
      ADDR_W'(`MSE_OFF_STAT):
      begin
        rd_word[`MSE_STAT_IDLE] = state_reg == mse_pkg::MSE_IDLE;
        rd_word[`MSE_STAT_DETECT] = state_reg == mse_pkg::MSE_DETECT;
        rd_word[`MSE_STAT_LISTEN] = state_reg == mse_pkg::MSE_LISTEN;
        rd_word[`MSE_STAT_BUSY] = busy_reg;
        rd_word[`MSE_STAT_PENDING] = pending_reg;
      end
      ADDR_W'(`MSE_OFF_INFO): rd_word = upset_info_reg;
      ADDR_W'(`MSE_OFF_IDX): rd_word = 32'(upset_memory_index_reg);
      ADDR_W'(`MSE_OFF_DIV): rd_word = 32'(div_reg);
      ADDR_W'(`MSE_OFF_RING): rd_word[`MSE_RING_PCIE] = pcie_mac_ring_include_reg;
      default: rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MSE_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? `MSE_RESP_OKAY : `MSE_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_reg <= `MSE_DIV_RESET;
    else if (wr_div)
    begin
      if (wstrb_reg[0])
        div_reg[7:0] <= wdata_reg[7:0];
      if (wstrb_reg[1])
        div_reg[15:8] <= wdata_reg[15:8];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pcie_mac_ring_include_reg <= 1'b0;
    else if (!pcie_enabled)
      pcie_mac_ring_include_reg <= 1'b0;
    else if (wr_ring)
      pcie_mac_ring_include_reg <= wdata_reg[`MSE_RING_PCIE];
  end

  // Ring membership per memory
  logic [NUM_MEM-1:0] in_ring;
  always_comb
  begin
    in_ring = '1;
    in_ring[PCIE_MEM] = pcie_mac_ring_include_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor speed: one step per divider tick
  logic tick;
  assign tick = tick_cnt_reg == '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !busy_reg || tick)
      tick_cnt_reg <= div_reg;
    else
      tick_cnt_reg <= tick_cnt_reg - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-memory detection stores
  logic listening;
  logic take_sel;
  assign listening = state_reg == mse_pkg::MSE_LISTEN;

  genvar g;
  generate
    for (g = 0; g < NUM_MEM; g++)
    begin : g_mem
      mse_pkg::mse_ind_s cur;
      mse_pkg::mse_ind_s nxt;
      logic rd_here;
      assign cur = store_reg[g];
      assign rd_here = take_sel && scan_reg == IW'(g);
      always_comb
      begin
        nxt = cur;
        if (rd_here || clear_reg[g])
          nxt = '0;
        if (mem_event[g].ue)
        begin
          if (listening && mem_event[g].addr_ok && !nxt.err)
          begin
            nxt.err = 1'b1;
            nxt.addr = mem_event[g].addr;
          end
          else
            nxt.err_ovf = 1'b1;
        end
        if (mem_event[g].ce)
        begin
          if (listening && mem_event[g].addr_ok && !nxt.err && !nxt.cor && !mem_event[g].ue)
          begin
            nxt.cor = 1'b1;
            nxt.addr = mem_event[g].addr;
          end
          else
            nxt.cor_ovf = 1'b1;
        end
      end
      // Flops hold their value over reset: no reset term
      always_ff @(posedge aclk)
      begin
        store_reg[g] <= nxt;
      end
      assign stored_reg[g] = nxt.err | nxt.err_ovf | nxt.cor | nxt.cor_ovf;
    end
  endgenerate

  assign mem_detect_clear = clear_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Step sequencer
  logic [NUM_MEM-1:0] avail;
  logic scan_last;
  assign avail = stored_reg & in_ring;
  assign scan_last = scan_reg == IW'(NUM_MEM - 1);
  assign take_sel = busy_reg && tick && state_reg != mse_pkg::MSE_LISTEN && started_reg
    && in_ring[scan_reg] && store_reg[scan_reg] != '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= mse_pkg::MSE_IDLE;
      step_request_reg <= 1'b0;
      busy_reg <= 1'b0;
      started_reg <= 1'b0;
      scan_reg <= '0;
      clear_reg <= '0;
      upset_info_reg <= '0;
      upset_memory_index_reg <= '0;
    end
    else
    begin
      clear_reg <= '0;
      if (!busy_reg && wr_ctrl && wdata_reg[`MSE_CTRL_STEP])
      begin
        step_request_reg <= 1'b1;
        busy_reg <= 1'b1;
        scan_reg <= (state_reg == mse_pkg::MSE_DETECT) ? upset_memory_index_reg + 1'b1 : '0;
      end
      else if (busy_reg && tick)
      begin
        unique case (state_reg)
          mse_pkg::MSE_LISTEN:
          begin
            state_reg <= mse_pkg::MSE_IDLE;
            step_request_reg <= 1'b0;
            busy_reg <= 1'b0;
          end
          mse_pkg::MSE_IDLE, mse_pkg::MSE_DETECT:
          begin
            if (!started_reg)
            begin
              clear_reg <= '1;
              started_reg <= 1'b1;
              state_reg <= mse_pkg::MSE_LISTEN;
              step_request_reg <= 1'b0;
              busy_reg <= 1'b0;
            end
            else if (take_sel)
            begin
              upset_info_reg <= store_reg[scan_reg];
              upset_memory_index_reg <= scan_reg;
              state_reg <= mse_pkg::MSE_DETECT;
              step_request_reg <= 1'b0;
              busy_reg <= 1'b0;
            end
            else if (scan_last || (state_reg == mse_pkg::MSE_DETECT && scan_reg == '0
              && upset_memory_index_reg == IW'(NUM_MEM - 1)))
            begin
              upset_info_reg <= '0;
              state_reg <= mse_pkg::MSE_LISTEN;
              step_request_reg <= 1'b0;
              busy_reg <= 1'b0;
            end
            else
              scan_reg <= scan_reg + 1'b1;
          end
          default:
          begin
            state_reg <= mse_pkg::MSE_IDLE;
            busy_reg <= 1'b0;
            step_request_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flag and interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending_reg <= 1'b0;
    else if (listening && |avail)
      pending_reg <= 1'b1;
    else if (state_reg != mse_pkg::MSE_LISTEN)
      pending_reg <= 1'b0;
  end

  // Drives source bit 20 of the interrupt controller
  assign integrity_interrupt = pending_reg;

endmodule // mse_monitor

/* testbench/mse_checker.sv */
`timescale 1ns/1ps
module mse_checker #(
  parameter int NUM_MEM = 8
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Monitor outputs
  input wire logic integrity_interrupt,
  input wire logic [NUM_MEM-1:0] mem_detect_clear
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  chk_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !integrity_interrupt && !s_axi_bvalid)
    else $error("outputs active after reset");
  chk_clr_shape: assert property (|mem_detect_clear |-> &mem_detect_clear || $onehot(mem_detect_clear))
    else $error("detect clear malformed");
  chk_clr_pulse: assert property (&mem_detect_clear |=> !(&mem_detect_clear))
    else $error("detect clear too long");
  chk_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
endmodule // mse_checker

/* testbench/mse_mem_model.sv */
`timescale 1ns/1ps
module mse_mem_model #(
  parameter int NUM_MEM = 8
)
(
  // Clock
  input wire logic aclk,
  // Upset pulses toward the monitor
  output mse_pkg::mse_event_s [NUM_MEM-1:0] mem_event
);
  initial mem_event = '0;
  ////////////////////////////////////////
  // One upset pulse, address left inverted after
  task automatic upset(input int m, input logic ue, input logic ce, input logic ok, input logic [27:0] a);
    @(posedge aclk);
    mem_event[m] <= '{ue, ce, ok, a};
    @(posedge aclk);
    mem_event[m] <= '{1'h0, 1'h0, 1'h0, ~a};
  endtask
endmodule // mse_mem_model

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "mse_defines.svh"
module tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pcie_enabled = 1'h0, clr_seen = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, integrity_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] mem_detect_clear;
  mse_pkg::mse_event_s [7:0] mem_event;
  mse_pkg::mse_ind_s exp_mem [8];
  integer seed = 32'h278D53C4;
  int err_count = 0;
  int checks = 0;
  always #20 aclk = ~aclk;
  always @(posedge aclk) if (&mem_detect_clear) clr_seen <= 1'h1;
  mse_monitor #(.NUM_MEM(8), .PCIE_MEM(7), .ADDR_W(12)) u_mse_monitor (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_event(mem_event),
    .pcie_enabled(pcie_enabled), .integrity_interrupt(integrity_interrupt), .mem_detect_clear(mem_detect_clear));
  mse_mem_model #(.NUM_MEM(8)) u_mse_mem_model (.aclk(aclk), .mem_event(mem_event));
  ////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      n++;
    end
    while (s_axi_bvalid !== 1'h1 && n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 100)
      err_count++;
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      n++;
    end
    while (s_axi_rvalid !== 1'h1 && n < 100);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 100)
      err_count++;
  endtask
  // Expected store after one upset
  function automatic mse_pkg::mse_ind_s upd(mse_pkg::mse_ind_s o, logic ue, logic ce, logic ok, logic [27:0] a,
    logic lis);
    upd = o;
    if (ue && ok && lis && !o.err)
    begin
      upd.err = 1'h1;
      upd.addr = a;
    end
    else if (ue)
      upd.err_ovf = 1'h1;
    if (ce && ok && lis && !upd.err && !upd.cor)
    begin
      upd.cor = 1'h1;
      upd.addr = a;
    end
    else if (ce)
      upd.cor_ovf = 1'h1;
  endfunction
  task automatic hit(input int m, input logic ue, input logic ce, input logic ok, input logic lis);
    logic [27:0] a;
    a = 28'($random(seed));
    u_mse_mem_model.upset(m, ue, ce, ok, a);
    exp_mem[m] = upd(exp_mem[m], ue, ce, ok, a, lis);
  endtask
  task automatic step(input bit slow);
    int n;
    wr(`MSE_OFF_CTRL, 32'h1);
    check("step resp", resp, `MSE_RESP_OKAY);
    if (slow)
    begin
      rd(`MSE_OFF_CTRL);
      check("step held", rdat, 32'h1);
      rd(`MSE_OFF_STAT);
      check("busy", rdat[`MSE_STAT_BUSY], 1'h1);
    end
    n = 0;
    do
    begin
      rd(`MSE_OFF_CTRL);
      n++;
    end
    while (rdat[`MSE_CTRL_STEP] !== 1'h0 && n < 300);
    if (n >= 300)
      err_count++;
    rd(`MSE_OFF_STAT);
  endtask
  // Leaves listen, reads every stored upset of memories 0 to 6, returns to listen
  task automatic drain(input int ih, input bit slow);
    step(1'h0);
    check("stat idle", rdat, 32'h1);
    check("irq off", integrity_interrupt, 1'h0);
    if (ih >= 0)
      hit(ih, 1'h0, 1'h1, 1'h1, 1'h0);
    for (int m = 0; m < 7; m++)
      if (exp_mem[m] !== '0)
      begin
        step(slow);
        check("stat detect", rdat, 32'h2);
        rd(`MSE_OFF_INFO);
        check("info", rdat, exp_mem[m]);
        rd(`MSE_OFF_IDX);
        check("index", rdat, m);
        exp_mem[m] = '0;
      end
    step(1'h0);
    check("stat listen", rdat, 32'h4);
  endtask
  ////////////////////////////////////////
  initial
  begin
    foreach (exp_mem[i])
      exp_mem[i] = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`MSE_OFF_STAT);
    check("stat reset", rdat, 32'h1);
    rd(`MSE_OFF_DIV);
    check("div reset", rdat, `MSE_DIV_RESET);
    rd(12'h018);
    check("unmapped read", rdat, 32'h0);
    check("unmapped read resp", resp, `MSE_RESP_SLVERR);
    wr(12'h018, $random(seed));
    check("unmapped write", resp, `MSE_RESP_SLVERR);
    for (int e = 0; e < 2; e++)
    begin
      pcie_enabled <= e[0];
      wr(`MSE_OFF_RING, 32'h1);
      rd(`MSE_OFF_RING);
      check("ring", rdat, e);
    end
    wr(`MSE_OFF_RING, 32'h0);
    $display("test registers done");
    u_mse_mem_model.upset(2, 1'h1, 1'h0, 1'h1, 28'h0ABCDEF);
    check("irq idle", integrity_interrupt, 1'h0);
    wr(`MSE_OFF_DIV, 32'h0);
    step(1'h0);
    check("first step", rdat, 32'h4);
    check("detect clear", clr_seen, 1'h1);
    hit(7, 1'h1, 1'h0, 1'h1, 1'h1);
    repeat (4) @(posedge aclk);
    check("irq ring out", integrity_interrupt, 1'h0);
    hit(1, 1'h1, 1'h0, 1'h1, 1'h1);
    hit(1, 1'h0, 1'h1, 1'h1, 1'h1);
    hit(3, 1'h0, 1'h1, 1'h1, 1'h1);
    hit(4, 1'h1, 1'h0, 1'h0, 1'h1);
    hit(6, 1'h0, 1'h1, 1'h0, 1'h1);
    for (int n = 0; n < 20 && integrity_interrupt !== 1'h1; n++)
      @(posedge aclk);
    check("irq", integrity_interrupt, 1'h1);
    rd(`MSE_OFF_STAT);
    check("pending", rdat, 32'h14);
    drain(-1, 1'h0);
    $display("test listen readout done");
    hit(0, 1'h0, 1'h1, 1'h1, 1'h1);
    hit(5, 1'h1, 1'h0, 1'h1, 1'h1);
    wr(`MSE_OFF_DIV, 32'h20 | ($random(seed) & 32'hF));
    drain(6, 1'h1);
    $display("test idle upset done");
    finish_test();
  end
  initial
  begin
    #2000000;
    err_count++;
    finish_test();
  end
endmodule // tb
bind mse_monitor mse_checker #(.NUM_MEM(NUM_MEM)) u_mse_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .integrity_interrupt(integrity_interrupt), .mem_detect_clear(mem_detect_clear));
